// [bench/tb_pll_and_regulator_config.sv]
/*
 * self-checking bench for the pll and core regulator configuration block.
 * assumes: pll_cfg_pkg compiled first; the bench drives the control beats
 * and the lock pin itself, with no far-side model.
 */
module tb_pll_and_regulator_config
  import pll_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // signals and instance
  // ****************************************************************
  logic clk_i;
  logic rst_n_i;
  ctl_beat_s ctl_i;
  logic [7:0] rd_data_o;
  logic rd_valid_o;
  logic pll_lock_pin_i;
  pll_apply_s pll_o;
  logic [1:0] core_regulator_out_o;
  int num_errors;
  int cmp_count;

  pll_and_regulator_config dut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ctl_i(ctl_i),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .pll_lock_pin_i(pll_lock_pin_i),
    .pll_o(pll_o),
    .core_regulator_out_o(core_regulator_out_o)
  );

  // 50 mhz clock
  always #10 clk_i = ~clk_i;

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // compare and count
  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // compare the applied pll settings as a whole
  task automatic chk_pll(input string name, input pll_apply_s exp);
    chk(name, {7'h0, exp}, {7'h0, pll_o});
  endtask

  // one control beat, launched at a rising edge
  task automatic beat(input int s, w, r, p, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    ctl_i <= '{s[0], w[0], r[0], p[0], a, d};
  endtask

  // read one byte at the pointer, answer one cycle later
  task automatic rd_byte(input string name, input logic [7:0] exp);
    beat(0, 0, 1, 0, 16'h0, 8'h0);
    beat(0, 0, 0, 0, 16'h0, 8'h0);
    #1;
    chk({name, " valid"}, 48'h1, {47'h0, rd_valid_o});
    chk(name, {40'h0, exp}, {40'h0, rd_data_o});
  endtask

  // pll burst of n bytes, most significant first, then wait for apply
  task automatic wr_pll(input logic [47:0] w, input int n);
    beat(1, 0, 0, 0, 16'h4002, 8'h0);
    for (int i = 0; i < n; i++) begin
      beat(0, 1, 0, 0, 16'h0, w[47-8*i -: 8]);
    end
    beat(0, 0, 0, 1, 16'h0, 8'h0);
    repeat (4) beat(0, 0, 0, 0, 16'h0, 8'h0);
    #1;
  endtask

  // read back all six pll bytes
  task automatic rd_pll(input logic [47:0] exp);
    beat(1, 0, 0, 0, 16'h4002, 8'h0);
    for (int i = 0; i < 6; i++) begin
      rd_byte("pll byte", exp[47-8*i -: 8]);
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    beat(0, 0, 0, 0, 16'h0, 8'h0);
    #1;
    chk_pll("pll_o reset", pll_apply_s'{1'b1, 1'b1, 3'h1, 4'h3, 16'h0287, 16'h0753});
    chk("regulator reset", 48'h1, {46'h0, core_regulator_out_o});
    rd_pll(48'h0753_0287_1901);
  endtask

  task automatic t_regulator();
    for (int c = 0; c < 4; c++) begin
      beat(1, 0, 0, 0, 16'h4001, 8'h0);
      beat(0, 1, 0, 0, 16'h0, {5'h1F, c[1:0], 1'b1});
      repeat (2) beat(0, 0, 0, 0, 16'h0, 8'h0);
      #1;
      chk("regulator level", {46'h0, c[1:0]}, {46'h0, core_regulator_out_o});
      beat(1, 0, 0, 0, 16'h4001, 8'h0);
      rd_byte("regulator read", {5'h0, c[1:0], 1'b0});
    end
  endtask

  task automatic t_unmapped();
    beat(1, 0, 0, 0, 16'h4008, 8'h0);
    beat(0, 1, 0, 0, 16'h0, 8'hFF);
    beat(1, 0, 0, 0, 16'h4008, 8'h0);
    rd_byte("unmapped read", 8'h00);
    chk("regulator kept", 48'h3, {46'h0, core_regulator_out_o});
  endtask

  task automatic t_pll_write();
    wr_pll(48'h007D_000C_A3FF, 6);
    chk_pll("pll_o fractional", pll_apply_s'{1'b1, 1'b1, 3'h2, 4'h4, 16'h000C, 16'h007D});
    rd_pll(48'h007D_000C_2301);
    wr_pll(48'h1111_2222_3333, 5);
    chk_pll("pll_o short burst", pll_apply_s'{1'b1, 1'b1, 3'h2, 4'h4, 16'h000C, 16'h007D});
  endtask

  task automatic t_lock();
    @(posedge clk_i);
    pll_lock_pin_i <= 1'b1;
    repeat (5) beat(0, 0, 0, 0, 16'h0, 8'h0);
    pll_lock_pin_i <= 1'b0;
    repeat (3) beat(0, 0, 0, 0, 16'h0, 8'h0);
    rd_pll(48'h007D_000C_2303);
  endtask

  task automatic t_integer_n();
    wr_pll(48'h007D_000C_2600, 6);
    chk_pll("pll_o integer-n", pll_apply_s'{1'b0, 1'b0, 3'h4, 4'h4, 16'h0, 16'h007D});
    rd_pll(48'h007D_000C_2602);
  endtask

  // regulator byte then six pll bytes in one burst from the regulator address
  task automatic t_auto_inc();
    logic [47:0] w;
    w = 48'h007D_000C_2501;
    beat(1, 0, 0, 0, 16'h4001, 8'h0);
    beat(0, 1, 0, 0, 16'h0, 8'h00);
    for (int i = 0; i < 6; i++) begin
      beat(0, 1, 0, 0, 16'h0, w[47-8*i -: 8]);
    end
    beat(0, 0, 0, 1, 16'h0, 8'h0);
    repeat (4) beat(0, 0, 0, 0, 16'h0, 8'h0);
    #1;
    chk("regulator via burst", 48'h0, {46'h0, core_regulator_out_o});
    chk_pll("pll_o divide by 3", pll_apply_s'{1'b1, 1'b1, 3'h3, 4'h4, 16'h000C, 16'h007D});
    rd_pll(48'h007D_000C_2503);
  endtask

  // reset in mid-run clears lock and restores every setting
  task automatic t_mid_reset();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk_pll("pll_o in reset", '0);
    chk("rd_valid in reset", 48'h0, {47'h0, rd_valid_o});
    chk("regulator in reset", 48'h1, {46'h0, core_regulator_out_o});
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
  endtask

  // ****************************************************************
  // verdict and main sequence
  // ****************************************************************
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog, well beyond the roughly 180 cycles the tests take
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end

  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    ctl_i = '0;
    pll_lock_pin_i = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_regulator();
    t_unmapped();
    t_pll_write();
    t_lock();
    t_integer_n();
    t_auto_inc();
    t_mid_reset();
    report_and_stop();
  end
endmodule // tb_pll_and_regulator_config

// [hdl/pll_and_regulator_config.sv]
/*
 * pll and core regulator configuration registers behind the serial
 * control bus front end; drives the pll and regulator settings.
 * assumes: control beats come from logic on clk_i; the lock pin comes
 * from the analog pll and is asynchronous.
 */
`include "pll_cfg_regs.svh"

// Overview of operation
// - pll settings bit 0 turns the pll on or off; resets to on.
// - regulator bits 2:1 pick 1.5, 1.4, 1.6, 1.7 volts; reset 01.
// - denominator is 16 bits in bits 47:32, reset 0x0753.
// - numerator is 16 bits in bits 31:16, reset 0x0287.
// - integer multiplier bits 14:11, values 2 to 8, reset 3; software keeps range.
// - pre-divider bits 10:9 divide reference by 1, 2, 3 or 4; reset 00.
// - bit 1 is read-only sticky lock flag; writes ignored.
// - bit 8 selects fractional or integer-n; integer-n forces fraction zero.
// - all six pll bytes come in one burst; applied only as a whole.
// - pll output is reference over divider times multiplier plus num over den.
module pll_and_regulator_config (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control bus beats
  input wire pll_cfg_pkg::ctl_beat_s ctl_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // analog side
  input wire logic pll_lock_pin_i,
  output pll_cfg_pkg::pll_apply_s pll_o,
  output logic [1:0] core_regulator_out_o
);
  import pll_cfg_pkg::*;

  logic [15:0] ptr_r;
  logic [2:0] rd_idx_r;
  logic [7:0] reg_ctl_r;
  pll_word_s pll_r;
  pll_apply_s apply_r;
  logic lock_s1_r;
  logic lock_s2_r;
  logic lock_r;
  logic [7:0] rd_data_r;
  logic rd_valid_r;
  logic [47:0] staged;
  logic complete;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire hit_reg = (ptr_r == `REGULATOR_ADDR);
  wire hit_pll = (ptr_r == `PLL_ADDR);
  wire reg_we = ctl_i.wr && hit_reg;
  wire pll_we = ctl_i.wr && hit_pll;
  // bus stop with a full six-byte set is the only way in
  wire apply = ctl_i.stop && hit_pll && complete;
  wire [47:0] pll_view = {pll_r[47:2], lock_r, pll_r.enable};
  wire [2:0] rd_sel = 3'h5 - rd_idx_r;
  wire [47:0] pll_shift = pll_view >> {rd_sel, 3'b000};
  wire [7:0] rd_byte = hit_reg ? reg_ctl_r : (hit_pll ? pll_shift[7:0] : 8'h00);
  wire [47:0] pll_nxt = (pll_r & ~`PLL_WMASK) | (staged & `PLL_WMASK);

  // ****************************************************************
  // burst collector
  // ****************************************************************
  pll_burst_collect u_collect (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .restart_i(ctl_i.start),
    .byte_we_i(pll_we),
    .byte_i(ctl_i.wdata),
    .word_o(staged),
    .complete_o(complete)
  );

  // ****************************************************************
  // address pointer
  // ****************************************************************
  // the pll register keeps the pointer; other addresses advance
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) ptr_r <= 16'h0000;
    else if (ctl_i.start) ptr_r <= ctl_i.addr;
    else if ((ctl_i.wr || ctl_i.rd) && !hit_pll) ptr_r <= ptr_r + 16'h0001;
  end

  // read byte index inside the pll register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rd_idx_r <= 3'h0;
    else if (ctl_i.start) rd_idx_r <= 3'h0;
    else if (ctl_i.rd && hit_pll && rd_idx_r != 3'h5) rd_idx_r <= rd_idx_r + 3'h1;
  end

  // ****************************************************************
  // regulator control
  // ****************************************************************
  // level write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) reg_ctl_r <= `REGULATOR_RESET;
    else if (reg_we) reg_ctl_r <= ctl_i.wdata & `REGULATOR_WMASK;
  end

  // ****************************************************************
  // pll settings
  // ****************************************************************
  // whole-set update
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pll_r <= `PLL_RESET;
    else if (apply) pll_r <= pll_nxt;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      apply_r <= '0;
    end else begin
      apply_r.enable <= pll_r.enable;
      apply_r.fractional <= pll_r.fractional;
      apply_r.xdiv <= xdiv_value(pll_r.xdiv_code);
      apply_r.mult <= pll_r.mult;
      apply_r.num <= pll_r.fractional ? pll_r.num : 16'h0000;
      apply_r.den <= pll_r.den;
    end
  end

  // ****************************************************************
  // lock flag
  // ****************************************************************
  // pin synchroniser
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
    end else begin
      lock_s1_r <= pll_lock_pin_i;
      lock_s2_r <= lock_s1_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) lock_r <= 1'b0;
    else if (lock_s2_r) lock_r <= 1'b1;
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // registered read byte; valid is a one-cycle pulse
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= ctl_i.rd;
      if (ctl_i.rd) rd_data_r <= rd_byte;
    end
  end

  assign rd_data_o = rd_data_r;
  assign rd_valid_o = rd_valid_r;
  assign pll_o = apply_r;
  assign core_regulator_out_o = reg_ctl_r[`REG_LEVEL_HI:`REG_LEVEL_LO];

  // ****************************************************************
  // checks
  // ****************************************************************
  // all checks run on clk_i; reset disables them
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_apply;
    apply ##1 1'b1;
  endsequence

  // read of the pll low byte, which carries the lock flag
  sequence s_lock_read;
    ctl_i.rd && hit_pll && (rd_idx_r == 3'h5);
  endsequence

  sequence s_lock_quiet;
    !lock_s2_r && !lock_r;
  endsequence

  a_enable_follow: assert property (s_apply |=> pll_o.enable == $past(staged[0], 2))
    else $error("pll enable not applied");
  a_level_write: assert property (reg_we |=> core_regulator_out_o == $past(ctl_i.wdata[2:1]))
    else $error("regulator level not written");
  a_den_apply: assert property (s_apply |=> pll_o.den == $past(staged[47:32], 2))
    else $error("denominator not applied");
  a_num_frac: assert property (s_apply |=>
    pll_o.num == ($past(staged[8], 2) ? $past(staged[31:16], 2) : 16'h0000))
    else $error("numerator mismatch");
  a_mult_cause: assert property (!$stable(pll_r.mult) |-> $past(apply))
    else $error("multiplier changed without apply");
  a_xdiv_map: assert property (rst_n_i |=> pll_o.xdiv == {1'b0, $past(pll_r.xdiv_code)} + 3'h1)
    else $error("divider value wrong");
  a_lock_sticky: assert property (lock_r |=> lock_r)
    else $error("lock flag dropped");
  a_lock_set: assert property (lock_s2_r |=> lock_r)
    else $error("lock not captured");
  a_intn_zero: assert property (!pll_r.fractional |=> pll_o.num == 16'h0000)
    else $error("fraction not zero in integer-n");
  a_partial_drop: assert property (ctl_i.stop && !complete && !apply |=> $stable(pll_r))
    else $error("partial burst applied");
  a_pll_hold: assert property (!apply |=> $stable(pll_r))
    else $error("pll settings changed without apply");
  a_level_hold: assert property (!reg_we |=> $stable(core_regulator_out_o))
    else $error("regulator level changed without write");
  a_mult_apply: assert property (s_apply |=> pll_o.mult == $past(staged[14:11], 2))
    else $error("multiplier not applied");
  a_frac_apply: assert property (s_apply |=> pll_o.fractional == $past(staged[8], 2))
    else $error("pll type not applied");
  a_lock_read: assert property (s_lock_read |=> rd_data_o[`PLL_LOCK_BIT] == $past(lock_r))
    else $error("lock flag read wrong");
  a_lock_quiet: assert property (s_lock_quiet |=> !lock_r)
    else $error("lock set without pin");
endmodule // pll_and_regulator_config

// [hdl/pll_burst_collect.sv]
/*
 * collects the bytes of one burst aimed at the pll register, most
 * significant byte first, and flags a burst of exactly six bytes.
 * assumes: restart pulses at the start of every burst.
 */
`include "pll_cfg_regs.svh"

module pll_burst_collect (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // byte stream
  input wire logic restart_i,
  input wire logic byte_we_i,
  input wire logic [7:0] byte_i,
  // assembled word
  output logic [47:0] word_o,
  output logic complete_o
);
  import pll_cfg_pkg::*;

  logic [2:0] count_r;
  logic over_r;
  logic [47:0] word_r;

  // ****************************************************************
  // byte shift and count
  // ****************************************************************
  // more than six bytes spoils the burst until the next restart
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= 3'h0;
      over_r <= 1'b0;
      word_r <= 48'h0;
    end else if (restart_i) begin
      count_r <= 3'h0;
      over_r <= 1'b0;
    end else if (byte_we_i) begin
      word_r <= {word_r[39:0], byte_i};
      if (count_r == `PLL_BYTES) over_r <= 1'b1;
      else count_r <= count_r + 3'h1;
    end
  end

  assign word_o = word_r;
  assign complete_o = (count_r == `PLL_BYTES) && !over_r;
endmodule // pll_burst_collect

// [hdl/pll_cfg_pkg.sv]
/*
 * types shared by the pll configuration block and its burst collector.
 * assumes: pll_cfg_regs.svh on the include path.
 */
package pll_cfg_pkg;
  `include "pll_cfg_regs.svh"

  // ****************************************************************
  // stored 48-bit pll settings word
  // ****************************************************************
  typedef struct packed {
    logic [15:0] den;
    logic [15:0] num;
    logic rsv15;
    logic [3:0] mult;
    logic [1:0] xdiv_code;
    logic fractional;
    logic [5:0] rsv_lo;
    logic lock;
    logic enable;
  } pll_word_s;

  // ****************************************************************
  // settings as applied to the analog pll
  // ****************************************************************
  typedef struct packed {
    logic enable;
    logic fractional;
    logic [2:0] xdiv;
    logic [3:0] mult;
    logic [15:0] num;
    logic [15:0] den;
  } pll_apply_s;

  // ****************************************************************
  // one beat from the serial control front end
  // ****************************************************************
  typedef struct packed {
    logic start;
    logic wr;
    logic rd;
    logic stop;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ctl_beat_s;

  // input divider code to divisor value (code 0 passes undivided)
  function automatic logic [2:0] xdiv_value(input logic [1:0] code);
    xdiv_value = {1'b0, code} + 3'h1;
  endfunction
endpackage

// [hdl/pll_cfg_regs.svh]
/*
 * register offsets, field positions, reset values and byte counts
 * for the pll and core regulator configuration block.
 * assumes: included by bare name from the package and design files.
 */
`ifndef PLL_CFG_REGS_SVH
`define PLL_CFG_REGS_SVH

// ****************************************************************
// register addresses on the serial control bus
// ****************************************************************
`define REGULATOR_ADDR 16'h4001
`define PLL_ADDR 16'h4002

// ****************************************************************
// field positions
// ****************************************************************
`define REG_LEVEL_HI 2
`define REG_LEVEL_LO 1
`define PLL_LOCK_BIT 1

// ****************************************************************
// reset values and write masks
// ****************************************************************
`define REGULATOR_RESET 8'h02
`define REGULATOR_WMASK 8'h06
`define PLL_RESET 48'h0753_0287_1901
`define PLL_WMASK 48'hFFFF_FFFF_7F01
`define PLL_BYTES 3'h6

`endif
